/* File: core/fnp_nan_unit.v */
// NaN propagation and invalid-operation result selection for one operation.
// Assumes the pipeline presents both operands with a one-cycle valid pulse and
// supplies the invalid mask and execution mode alongside.
//
// What this block does
// [RL1] Unmasked invalid on SNaN: signal, suppress write
// [RL2] Quieting sets top fraction bit only
// [RL3] Masked SNaN sets invalid flag, delivers QNaN
// [RL4] Masked invalid, no NaNs: deliver indefinite
// [RL5] SNaN+QNaN: stack picks QNaN, SIMD first
// [RL6] Two SNaNs: stack larger significand, SIMD first
// [RL7] Two QNaNs: same choice, returned unchanged
// [RL8] SNaN with number: return quieted SNaN
// [RL9] QNaN with number: return QNaN unchanged
// [RL10] Single operand SNaN: return it quieted
// [RL11] Single operand QNaN: return it unchanged
// [RL12] Two selection policies chosen by mode
// [RL13] SIMD first source supplied on operand a
// [RL14] Payload bits preserved apart from quiet bit
// [RL15] One indefinite encoding per precision
// [RL16] NaN: exponent all ones, fraction non-zero
// [RL17] Top fraction bit set means quiet
// [RL18] Never output a signaling NaN
// [RL19] Indefinite: sign set, quiet bit only
// [RL20] Pipeline supplies mask, mode; honours suppress
`timescale 1ns/1ps
`include "fnp_regs.vh"

module fnp_nan_unit
#(
  parameter W = 80
)
(
  // Clock and reset
  input  wire         sys_clk,
  input  wire         reset,
  // Operation request
  input  wire         op_valid,
  input  wire [1:0]   op_prec,
  input  wire         op_mode,
  input  wire         op_unary,
  input  wire         op_invalid,
  input  wire         inv_mask,
  input  wire [W-1:0] src_a,
  input  wire [W-1:0] src_b,
  // Result
  output reg          res_valid,
  output reg          res_is_nan,
  output reg  [W-1:0] res_data,
  output reg          res_write,
  output reg          inv_flag,
  output reg          inv_trap
);

  // Per-precision classification of one operand.
  function [2:0] fnp_class; // {is_nan, is_snan, is_qnan}
    input [W-1:0] v;
    input [1:0]   prec;
    reg           nan;
    reg           q;
    begin
      nan = 1'b0;
      q   = 1'b0;
      case (prec)
        `FNP_PREC_SINGLE:
        begin
          nan = (&v[`FNP_SP_EXP_HI:`FNP_SP_EXP_LO]) && (|v[`FNP_SP_QBIT:0]); // RL16
          q   = v[`FNP_SP_QBIT]; // RL17
        end
        `FNP_PREC_DOUBLE:
        begin
          nan = (&v[`FNP_DP_EXP_HI:`FNP_DP_EXP_LO]) && (|v[`FNP_DP_QBIT:0]); // RL16
          q   = v[`FNP_DP_QBIT]; // RL17
        end
        default:
        begin
          // The integer bit is not part of the fraction, so it is not tested.
          nan = (&v[`FNP_EP_EXP_HI:`FNP_EP_EXP_LO]) && (|v[`FNP_EP_QBIT:0]); // RL16
          q   = v[`FNP_EP_QBIT]; // RL17
        end
      endcase
      fnp_class = {nan, nan & ~q, nan & q};
    end
  endfunction

  // Fraction field, plus the integer bit in extended, used for the larger-significand comparison.
  function [W-1:0] fnp_sig;
    input [W-1:0] v;
    input [1:0]   prec;
    begin
      fnp_sig = {W{1'b0}};
      case (prec)
        `FNP_PREC_SINGLE: fnp_sig[`FNP_SP_QBIT:0] = v[`FNP_SP_QBIT:0];
        `FNP_PREC_DOUBLE: fnp_sig[`FNP_DP_QBIT:0] = v[`FNP_DP_QBIT:0];
        default:          fnp_sig[`FNP_EP_EXP_LO-1:0] = v[`FNP_EP_EXP_LO-1:0];
      endcase
    end
  endfunction

  // Quieting touches the quiet bit alone, so sign, exponent and payload survive.
  function [W-1:0] fnp_quiet;
    input [W-1:0] v;
    input [1:0]   prec;
    begin
      fnp_quiet = v;
      case (prec)
        `FNP_PREC_SINGLE: fnp_quiet[`FNP_SP_QBIT] = 1'b1; // RL2 RL14
        `FNP_PREC_DOUBLE: fnp_quiet[`FNP_DP_QBIT] = 1'b1; // RL2 RL14
        default:          fnp_quiet[`FNP_EP_QBIT] = 1'b1; // RL2 RL14
      endcase
    end
  endfunction

  // Exactly one indefinite encoding per precision; upper bits read zero.
  function [W-1:0] fnp_indef;
    input [1:0] prec;
    begin
      fnp_indef = {W{1'b0}};
      case (prec)
        `FNP_PREC_SINGLE:
        begin
          fnp_indef[`FNP_SP_SIGN]                  = 1'b1; // RL19
          fnp_indef[`FNP_SP_EXP_HI:`FNP_SP_EXP_LO] = {8{1'b1}};
          fnp_indef[`FNP_SP_QBIT]                  = 1'b1; // RL15
        end
        `FNP_PREC_DOUBLE:
        begin
          fnp_indef[`FNP_DP_SIGN]                  = 1'b1; // RL19
          fnp_indef[`FNP_DP_EXP_HI:`FNP_DP_EXP_LO] = {11{1'b1}};
          fnp_indef[`FNP_DP_QBIT]                  = 1'b1; // RL15
        end
        default:
        begin
          fnp_indef[`FNP_EP_SIGN]                  = 1'b1; // RL19
          fnp_indef[`FNP_EP_EXP_HI:`FNP_EP_EXP_LO] = {15{1'b1}};
          fnp_indef[`FNP_EP_EXP_LO-1]              = 1'b1;
          fnp_indef[`FNP_EP_QBIT]                  = 1'b1; // RL15
        end
      endcase
    end
  endfunction

  wire [2:0]   cls_a = fnp_class(src_a, op_prec);
  wire [2:0]   cls_b = fnp_class(src_b, op_prec);
  wire         a_nan = cls_a[2];
  wire         a_sn  = cls_a[1];
  wire         a_qn  = cls_a[0];
  // A unary operation ignores operand b entirely.
  wire         b_nan = cls_b[2] & ~op_unary;
  wire         b_sn  = cls_b[1] & ~op_unary;
  wire         b_qn  = cls_b[0] & ~op_unary;
  wire         any_sn  = a_sn | b_sn;
  wire         any_nan = a_nan | b_nan;
  wire         a_larger = fnp_sig(src_a, op_prec) >= fnp_sig(src_b, op_prec);

  reg  [W-1:0] next_data;
  reg          next_nan;
  reg          next_inv;

  // Result selection.
  always @*
  begin
    next_data = {W{1'b0}};
    next_nan  = 1'b0;
    next_inv  = any_sn | (op_invalid & ~any_nan);
    if (a_nan && b_nan)
    begin
      next_nan = 1'b1;
      if (op_mode == `FNP_MODE_SIMD) // RL12
      begin
        // Operand a carries the first source in every SIMD form.
        next_data = fnp_quiet(src_a, op_prec); // RL5 RL6 RL7 RL13
      end
      else if (a_sn != b_sn)
      begin
        next_data = a_qn ? src_a : src_b; // RL5
      end
      else
      begin
        // Equal significands tie toward operand a.
        next_data = fnp_quiet(a_larger ? src_a : src_b, op_prec); // RL6 RL7
      end
    end
    else if (a_nan)
    begin
      next_nan  = 1'b1;
      next_data = fnp_quiet(src_a, op_prec); // RL8 RL9 RL10 RL11 RL18
    end
    else if (b_nan)
    begin
      next_nan  = 1'b1;
      next_data = fnp_quiet(src_b, op_prec); // RL8 RL9 RL18
    end
    else if (op_invalid)
    begin
      next_nan  = 1'b1;
      next_data = fnp_indef(op_prec); // RL4
    end
  end

  // Registered result stage.
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      res_valid  <= 1'b0;
      res_is_nan <= 1'b0;
      res_data   <= {W{1'b0}};
      res_write  <= 1'b0;
      inv_flag   <= 1'b0;
      inv_trap   <= 1'b0;
    end
    else
    begin
      res_valid  <= op_valid;
      res_is_nan <= op_valid & next_nan;
      if (op_valid)
      begin
        res_data <= next_data;
      end
      // The write is held off on a trap so the destination keeps its old value.
      res_write  <= op_valid & ~(next_inv & ~inv_mask); // RL1 RL20
      inv_flag   <= op_valid & next_inv & inv_mask; // RL3
      inv_trap   <= op_valid & next_inv & ~inv_mask; // RL1
    end
  end

endmodule

/* File: core/fnp_regs.vh */
// Constants for the NaN propagation unit: formats, field positions, modes.
// Included by the unit's design file; holds definitions only.
`ifndef FNP_REGS_VH
`define FNP_REGS_VH

// Precision select codes.
`define FNP_PREC_SINGLE 2'h0
`define FNP_PREC_DOUBLE 2'h1
`define FNP_PREC_EXT    2'h2

// Execution mode codes.
`define FNP_MODE_STACK  1'h0
`define FNP_MODE_SIMD   1'h1

// Single precision layout in the low 32 bits.
`define FNP_SP_SIGN     31
`define FNP_SP_EXP_HI   30
`define FNP_SP_EXP_LO   23
`define FNP_SP_QBIT     22

// Double precision layout in the low 64 bits.
`define FNP_DP_SIGN     63
`define FNP_DP_EXP_HI   62
`define FNP_DP_EXP_LO   52
`define FNP_DP_QBIT     51

// Extended precision layout: explicit integer bit at 63.
`define FNP_EP_SIGN     79
`define FNP_EP_EXP_HI   78
`define FNP_EP_EXP_LO   64
`define FNP_EP_QBIT     62

// Result latency of the registered output stage, in cycles.
`define FNP_LATENCY     1

`endif

/* File: test/fnp_nan_unit_asserts.sv */
// Checker for the NaN unit: answer timing, trap and quieting relations.
// Assumes one clock domain with a synchronous reset.
`timescale 1ns/1ps
module fnp_nan_unit_asserts (
  input logic        sys_clk, reset, op_valid, op_mode, op_unary, op_invalid, inv_mask,
  input logic [1:0]  op_prec,
  input logic [79:0] src_a, src_b, res_data,
  input logic        res_valid, res_is_nan, res_write, inv_flag, inv_trap
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire sp  = op_valid && op_prec == 2'h0;
  wire snp = sp && src_a[30:22] == 9'h1FE && |src_a[21:0];
  a_answer_next: assert property (op_valid |=> res_valid) else $error("late");
  a_idle_quiet: assert property (!op_valid |=> !(res_valid | res_write | inv_flag | inv_trap))
    else $error("stray pulse");
  a_trap_nowrite: assert property (inv_trap |-> !res_write) else $error("write");
  a_snan_trap: assert property (snp && !inv_mask |=> inv_trap) else $error("no trap");
  a_snan_flag: assert property (snp && inv_mask |=> inv_flag && res_write)
    else $error("no flag");
  a_sp_quiet: assert property (res_is_nan && $past(op_prec) == 2'h0 |-> res_data[22])
    else $error("signaling");
  a_dp_quiet: assert property (res_is_nan && $past(op_prec) == 2'h1 |-> res_data[51])
    else $error("signaling");
  a_first_src: assert property (sp && src_a[30:22] == 9'h1FF && (op_mode || op_unary)
    |=> res_data == $past(src_a)) else $error("source");
  c_trap: cover property (inv_trap);
  c_flag: cover property (inv_flag);
  c_write: cover property (res_write && !res_is_nan);
endmodule
bind fnp_nan_unit fnp_nan_unit_asserts u_chk (.sys_clk, .reset, .op_valid, .op_mode, .op_unary,
  .op_invalid, .inv_mask, .op_prec, .src_a, .src_b, .res_data, .res_valid, .res_is_nan,
  .res_write, .inv_flag, .inv_trap);

/* File: test/fnp_nan_unit_tb_top.sv */
// Bench for the NaN unit: table of NaN cases, then trap and reset.
// Assumes the unit answers one cycle after op_valid.
`timescale 1ns/1ps
`define CHK(x, y) begin num_checks++; if ((x) !== (y)) begin err_total++; $display("Error %0t got %h want %h", $time, x, y); end end
module fnp_nan_unit_tb_top;
  logic         sys_clk = 1'h0, reset = 1'h1, op_valid = 1'h0;
  logic         op_mode, op_unary, op_invalid, inv_mask;
  logic         res_valid, res_is_nan, res_write, inv_flag, inv_trap;
  logic [1:0]   op_prec;
  logic [79:0]  src_a, src_b, res_data, dest;
  logic [7:0]   wr_cnt, cnt0;
  logic [249:0] tbl [13];
  int           err_total = 0, num_checks = 0, cyc = 0;
  fnp_nan_unit u_dut (.sys_clk, .reset, .op_valid, .op_prec, .op_mode, .op_unary, .op_invalid,
    .inv_mask, .src_a, .src_b, .res_valid, .res_is_nan, .res_data, .res_write, .inv_flag,
    .inv_trap);
  fnp_wb_model u_wb (.sys_clk, .reset, .res_valid, .res_write, .res_data, .dest, .wr_cnt);
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 400)
    begin
      err_total++;
      complete_run;
    end
  end
  task complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task drv(input logic [3:0] c, input logic [1:0] p, input logic [79:0] a, b);
    {op_mode, op_unary, op_invalid, inv_mask} = c;
    {op_prec, src_a, src_b} = {p, a, b};
    op_valid = 1'h1;
    @(posedge sys_clk);
    #1;
  endtask
  initial
  begin
    {op_mode, op_unary, op_invalid, inv_mask, op_prec, src_a, src_b} = 166'h0;
    tbl = '{
      {4'h1,4'hD,2'h0,80'h7F800001,80'hFFC00005,80'hFFC00005},
      {4'h9,4'hD,2'h0,80'h7F800001,80'hFFC00005,80'h7FC00001},
      {4'h1,4'hD,2'h0,80'h7F800001,80'h7F800003,80'h7FC00003},
      {4'h9,4'hD,2'h0,80'h7F800001,80'h7F800003,80'h7FC00001},
      {4'h1,4'h9,2'h0,80'h7FC00002,80'hFFC00005,80'hFFC00005},
      {4'h9,4'h9,2'h0,80'h7FC00002,80'hFFC00005,80'h7FC00002},
      {4'h9,4'hD,2'h0,80'h3F800000,80'h7F800003,80'h7FC00003},
      {4'h1,4'h9,2'h0,80'hFFC00005,80'h3F800000,80'hFFC00005},
      {4'h5,4'hD,2'h0,80'hFF812345,80'h7FC00002,80'hFFC12345},
      {4'h5,4'h9,2'h0,80'h7FC00002,80'h7F800001,80'h7FC00002},
      {4'h3,4'hD,2'h0,80'h3F800000,80'h0,80'hFFC00000},
      {4'h1,4'hD,2'h1,80'h7FF0000000000001,80'h0,80'h7FF8000000000001},
      {4'h1,4'hD,2'h2,80'h7FFF8000000000000001,80'h0,80'h7FFFC000000000000001}};
    repeat (10) @(posedge sys_clk);
    #1 reset = 1'h0;
    for (int i = 0; i < 13; i++)
    begin
      drv(tbl[i][249:246], tbl[i][241:240], tbl[i][239:160], tbl[i][159:80]);
      `CHK({res_is_nan, inv_flag, inv_trap, res_write}, tbl[i][245:242])
      `CHK(res_data, tbl[i][79:0])
      `CHK(res_valid, 1'h1)
      $display("row %0d done", i);
    end
    op_valid = 1'h0;
    @(posedge sys_clk);
    #1 cnt0 = wr_cnt;
    `CHK(dest, tbl[12][79:0])
    drv(4'h1, 2'h0, 80'h3F800000, 80'h3F800000);
    `CHK({res_is_nan, inv_flag, inv_trap, res_write}, 4'h1)
    drv(4'h0, 2'h0, 80'h7F800001, 80'h3F800000);
    `CHK({inv_flag, inv_trap, res_write}, 3'h2)
    op_valid = 1'h0;
    repeat (2) @(posedge sys_clk);
    #1 `CHK(wr_cnt, cnt0 + 8'h1)
    $display("trap test done");
    {reset, op_valid} = 2'h3;
    repeat (2) @(posedge sys_clk);
    #1 `CHK({res_valid, inv_trap, wr_cnt}, 10'h0)
    {reset, op_valid} = 2'h0;
    $display("reset test done");
    complete_run;
  end
endmodule

/* File: test/fnp_wb_model.sv */
// Writeback stage model: updates the destination only when allowed.
// Assumes registered result pulses on sys_clk.
`timescale 1ns/1ps
module fnp_wb_model (
  input  wire        sys_clk, reset, res_valid, res_write,
  input  wire [79:0] res_data,
  output reg  [79:0] dest,
  output reg  [7:0]  wr_cnt
);
  // A count shows a missed suppress even when the data happens to match.
  always @(posedge sys_clk)
  begin
    if (reset)
      {dest, wr_cnt} <= 88'h0;
    else if (res_valid && res_write)
      {dest, wr_cnt} <= {res_data, wr_cnt + 8'h1};
  end
endmodule
